// File: hw/rsi_reset_init.sv
// reset kind capture and post-reset state sequencing
`timescale 1ns/1ps
`default_nettype none
module rsi_reset_init (
  input  wire logic               i_clock,
  input  wire logic               i_rst_n,
  input  wire logic               i_ce,
  input  wire logic               i_power_on_reset,
  input  wire logic               i_low_voltage_reset,
  input  wire logic               i_watchdog_timer_timeout,
  input  wire rsi_pkg::rsi_mode_t i_power_mode,
  input  wire logic               i_sleep_enter,
  input  wire logic               i_watchdog_timer_clear,
  output var  logic               o_cpu_reset,
  output var  rsi_pkg::rsi_kind_e o_reset_kind,
  output var  logic               o_timeout_flag,
  output var  logic               o_powerdown_flag,
  output var  logic               o_pc_clear,
  output var  logic               o_program_counter_low_clear,
  output var  logic               o_stack_ptr_top,
  output var  logic               o_int_disable_all,
  output var  logic               o_watchdog_timer_clear,
  output var  logic               o_time_base_clear,
  output var  logic               o_watchdog_timer_run,
  output var  logic               o_timer_off,
  output var  logic               o_port_set_high,
  output var  logic               o_regs_reload,
  output var  logic               o_regs_retain
);
  import rsi_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_HOLD,
    ST_UNUSED
  } rsi_state_e;

  function automatic logic is_standby(input rsi_mode_t mode);
    is_standby = (mode == MODE_IDLE) || (mode == MODE_SLEEP);
  endfunction : is_standby

  function automatic rsi_kind_e pick_kind(input logic [NUM_SRC-1:0] src,
                                          input rsi_mode_t mode);
    if (src[SRC_POR]) begin
      pick_kind = KIND_POR;
    end else if (src[SRC_LOW_VOLT]) begin
      pick_kind = KIND_LOW_VOLT;
    end else if (is_standby(mode)) begin
      pick_kind = KIND_WD_STANDBY;
    end else begin
      pick_kind = KIND_WD_RUN;
    end
  endfunction : pick_kind

  logic [NUM_SRC-1:0] src_s;
  logic               src_any;

  rsi_state_e st_q;
  rsi_state_e st_d;
  rsi_kind_e  kind_q;
  rsi_kind_e  kind_d;
  logic       tmo_q;
  logic       tmo_d;
  logic       pd_q;
  logic       pd_d;
  logic       cpu_rst_q;
  logic       cpu_rst_d;
  logic       wd_run_q;
  logic       wd_run_d;
  logic       pc_clr_q;
  logic       pc_clr_d;
  logic       pc_low_clr_q;
  logic       pc_low_clr_d;
  logic       sp_top_q;
  logic       sp_top_d;
  logic       int_dis_q;
  logic       int_dis_d;
  logic       wd_clr_q;
  logic       wd_clr_d;
  logic       tb_clr_q;
  logic       tb_clr_d;
  logic       tmr_off_q;
  logic       tmr_off_d;
  logic       port_hi_q;
  logic       port_hi_d;
  logic       reload_q;
  logic       reload_d;
  logic       retain_q;
  logic       retain_d;

  rsi_src_sync u_src_sync (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_src   ({i_watchdog_timer_timeout, i_low_voltage_reset,
               i_power_on_reset}),
    .o_src   (src_s)
  );

  assign src_any = |src_s;

  always_comb begin
    st_d         = st_q;
    kind_d       = kind_q;
    tmo_d        = tmo_q;
    pd_d         = pd_q;
    cpu_rst_d    = cpu_rst_q;
    wd_run_d     = wd_run_q;
    pc_clr_d     = 1'b0;
    pc_low_clr_d = 1'b0;
    sp_top_d     = 1'b0;
    int_dis_d    = 1'b0;
    wd_clr_d     = 1'b0;
    tb_clr_d  = 1'b0;
    tmr_off_d = 1'b0;
    port_hi_d = 1'b0;
    reload_d  = 1'b0;
    retain_d  = 1'b0;
    // core operations on the flags, overridden by a reset that applies
    if (i_watchdog_timer_clear) begin
      tmo_d = 1'b0;
      pd_d  = 1'b0;
    end
    if (i_sleep_enter) begin
      tmo_d = 1'b0;
      pd_d  = 1'b1;
    end
    unique case (st_q)
      ST_IDLE: begin
        if (src_any) begin
          st_d      = ST_HOLD;
          kind_d    = pick_kind(src_s, i_power_mode);
          cpu_rst_d = 1'b1;
          wd_run_d  = 1'b0;
        end
      end
      ST_HOLD: begin
        if (src_s[SRC_POR]) begin
          kind_d = KIND_POR;
        end
        if (!src_any) begin
          st_d      = ST_IDLE;
          cpu_rst_d    = 1'b0;
          pc_low_clr_d = 1'b1;
          sp_top_d     = 1'b1;
          wd_run_d     = 1'b1;
          unique case (kind_q)
            KIND_POR: begin
              tmo_d = 1'b0;
              pd_d  = 1'b0;
            end
            KIND_LOW_VOLT: begin
              tmo_d = tmo_q;
              pd_d  = pd_q;
            end
            KIND_WD_RUN: begin
              tmo_d = 1'b1;
              pd_d  = pd_q;
            end
            KIND_WD_STANDBY: begin
              tmo_d = 1'b1;
              pd_d  = 1'b1;
            end
          endcase
          if (kind_q == KIND_WD_STANDBY) begin
            retain_d = 1'b1;
          end else begin
            reload_d  = 1'b1;
            pc_clr_d  = 1'b1;
            int_dis_d = 1'b1;
            wd_clr_d  = 1'b1;
            tb_clr_d  = 1'b1;
            tmr_off_d = 1'b1;
            port_hi_d = 1'b1;
          end
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q      <= ST_HOLD;
      kind_q    <= KIND_POR;
      tmo_q        <= TIMEOUT_FLAG_RST;
      pd_q         <= POWERDOWN_FLAG_RST;
      cpu_rst_q    <= CPU_RESET_RST;
      wd_run_q     <= 1'b0;
      pc_clr_q     <= 1'b0;
      pc_low_clr_q <= 1'b0;
      sp_top_q     <= 1'b0;
      int_dis_q    <= 1'b0;
      wd_clr_q     <= 1'b0;
      tb_clr_q  <= 1'b0;
      tmr_off_q <= 1'b0;
      port_hi_q <= 1'b0;
      reload_q  <= 1'b0;
      retain_q  <= 1'b0;
    end else if (i_ce) begin
      st_q      <= st_d;
      kind_q    <= kind_d;
      tmo_q        <= tmo_d;
      pd_q         <= pd_d;
      cpu_rst_q    <= cpu_rst_d;
      wd_run_q     <= wd_run_d;
      pc_clr_q     <= pc_clr_d;
      pc_low_clr_q <= pc_low_clr_d;
      sp_top_q     <= sp_top_d;
      int_dis_q    <= int_dis_d;
      wd_clr_q     <= wd_clr_d;
      tb_clr_q  <= tb_clr_d;
      tmr_off_q <= tmr_off_d;
      port_hi_q <= port_hi_d;
      reload_q  <= reload_d;
      retain_q  <= retain_d;
    end
  end

  assign o_cpu_reset                 = cpu_rst_q;
  assign o_reset_kind                = kind_q;
  assign o_timeout_flag              = tmo_q;
  assign o_powerdown_flag            = pd_q;
  assign o_pc_clear                  = pc_clr_q;
  assign o_program_counter_low_clear = pc_low_clr_q;
  assign o_stack_ptr_top             = sp_top_q;
  assign o_int_disable_all           = int_dis_q;
  assign o_watchdog_timer_clear      = wd_clr_q;
  assign o_time_base_clear           = tb_clr_q;
  assign o_watchdog_timer_run        = wd_run_q;
  assign o_timer_off                 = tmr_off_q;
  assign o_port_set_high             = port_hi_q;
  assign o_regs_reload               = reload_q;
  assign o_regs_retain               = retain_q;

endmodule : rsi_reset_init
`default_nettype wire

// File: include/rsi_pkg.sv
// constants and types for the reset state initialiser
package rsi_pkg;

  localparam int unsigned NUM_SRC = 3;
  localparam int unsigned SRC_POR = 0;
  localparam int unsigned SRC_LOW_VOLT = 1;
  localparam int unsigned SRC_WD       = 2;

  typedef logic [1:0] rsi_mode_t;
  localparam rsi_mode_t MODE_FAST  = 2'h0;
  localparam rsi_mode_t MODE_SLOW  = 2'h1;
  localparam rsi_mode_t MODE_IDLE  = 2'h2;
  localparam rsi_mode_t MODE_SLEEP = 2'h3;

  typedef enum logic [1:0] {
    KIND_POR,
    KIND_LOW_VOLT,
    KIND_WD_RUN,
    KIND_WD_STANDBY
  } rsi_kind_e;

  localparam logic TIMEOUT_FLAG_RST   = 1'b0;
  localparam logic POWERDOWN_FLAG_RST = 1'b0;
  localparam logic CPU_RESET_RST      = 1'b1;

endpackage : rsi_pkg

// File: hw/rsi_src_sync.sv
// two-stage synchronisers for the reset source inputs
`timescale 1ns/1ps
`default_nettype none
module rsi_src_sync (
  input  wire logic                      i_clock,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_ce,
  input  wire logic [rsi_pkg::NUM_SRC-1:0] i_src,
  output var  logic [rsi_pkg::NUM_SRC-1:0] o_src
);
  import rsi_pkg::*;

  logic [NUM_SRC-1:0] meta_q;
  logic [NUM_SRC-1:0] meta_d;
  logic [NUM_SRC-1:0] sync_q;
  logic [NUM_SRC-1:0] sync_d;

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_sync
      always_comb begin
        meta_d[g] = i_src[g];
        sync_d[g] = meta_q[g];
      end
    end
  endgenerate

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (i_ce) begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign o_src = sync_q;

endmodule : rsi_src_sync
`default_nettype wire

// File: dv/rsi_properties.sv
// port assertions for the reset state initialiser
`timescale 1ns/1ps
`default_nettype none
module rsi_properties (
  input wire logic               i_clock,
  input wire logic               i_rst_n,
  input wire logic               i_power_on_reset,
  input wire logic               o_cpu_reset,
  input wire rsi_pkg::rsi_kind_e o_reset_kind,
  input wire logic               o_timeout_flag,
  input wire logic               o_powerdown_flag,
  input wire logic               o_pc_clear,
  input wire logic               o_program_counter_low_clear,
  input wire logic               o_stack_ptr_top,
  input wire logic               o_int_disable_all,
  input wire logic               o_watchdog_timer_run,
  input wire logic               o_regs_reload,
  input wire logic               o_regs_retain
);
  import rsi_pkg::*;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  a_por_flags: assert property (
    $fell(o_cpu_reset) && o_reset_kind == KIND_POR
    |-> !o_timeout_flag && !o_powerdown_flag) else $error("por flags");
  a_low_volt_flags: assert property (
    $fell(o_cpu_reset) && o_reset_kind == KIND_LOW_VOLT
    |-> $stable(o_timeout_flag) && $stable(o_powerdown_flag))
    else $error("low voltage flags");
  a_wd_run_flags: assert property (
    $fell(o_cpu_reset) && o_reset_kind == KIND_WD_RUN
    |-> o_timeout_flag && $stable(o_powerdown_flag))
    else $error("running watchdog flags");
  a_standby_flags: assert property (
    $fell(o_cpu_reset) && o_reset_kind == KIND_WD_STANDBY
    |-> o_timeout_flag && o_powerdown_flag) else $error("standby flags");
  a_full_reload: assert property (
    $fell(o_cpu_reset) && o_reset_kind != KIND_WD_STANDBY
    |-> o_int_disable_all && o_regs_reload && o_pc_clear && !o_regs_retain)
    else $error("reload pulses");
  a_standby_keep: assert property (
    $fell(o_cpu_reset) && o_reset_kind == KIND_WD_STANDBY
    |-> o_regs_retain && !o_regs_reload && !o_pc_clear
    && o_program_counter_low_clear) else $error("retain pulses");
  a_stack_top: assert property (
    $fell(o_cpu_reset) |-> o_stack_ptr_top ##1 !o_stack_ptr_top)
    else $error("stack pulse");
  a_wd_starts: assert property (
    $fell(o_cpu_reset) |-> $rose(o_watchdog_timer_run))
    else $error("watchdog start");
  a_por_seen: assert property (
    $rose(i_power_on_reset) && !o_cpu_reset
    |-> ##[1:4] o_cpu_reset && o_reset_kind == KIND_POR)
    else $error("por not taken");
  c_standby: cover property ($fell(o_cpu_reset)
    && o_reset_kind == KIND_WD_STANDBY);
  c_low_volt: cover property ($fell(o_cpu_reset)
    && o_reset_kind == KIND_LOW_VOLT);
  c_run: cover property ($fell(o_cpu_reset)
    && o_reset_kind == KIND_WD_RUN);
  c_upgrade: cover property ($past(o_cpu_reset) && o_cpu_reset
    && $changed(o_reset_kind) && o_reset_kind == KIND_POR);
endmodule : rsi_properties
`default_nettype wire

// File: dv/tb_top.sv
// self-checking bench for the reset state initialiser
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rsi_pkg::*;
  logic i_clock = 1'b0, i_rst_n = 1'b0, ce = 1'b1, slp = 1'b0, wclr = 1'b0;
  logic [2:0] src = 3'h0;
  rsi_mode_t mode = MODE_FAST;
  rsi_kind_e kind;
  logic tmo, pdn, crst, run;
  logic [9:0] pul;
  logic [4:0] tbl [8] = '{5'h01, 5'h0A, 5'h04, 5'h0C,
                          5'h14, 5'h1C, 5'h16, 5'h07};
  int error_cnt = 0, n_checks = 0;
  always #10 i_clock = ~i_clock;
  rsi_reset_init i_rsi_reset_init (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_ce(ce), .i_power_on_reset(src[0]), .i_low_voltage_reset(src[1]),
    .i_watchdog_timer_timeout(src[2]), .i_power_mode(mode),
    .i_sleep_enter(slp), .i_watchdog_timer_clear(wclr),
    .o_cpu_reset(crst), .o_reset_kind(kind), .o_timeout_flag(tmo),
    .o_powerdown_flag(pdn), .o_pc_clear(pul[0]),
    .o_program_counter_low_clear(pul[1]), .o_stack_ptr_top(pul[2]),
    .o_int_disable_all(pul[3]), .o_watchdog_timer_clear(pul[4]),
    .o_time_base_clear(pul[5]), .o_timer_off(pul[6]),
    .o_port_set_high(pul[7]), .o_regs_reload(pul[8]),
    .o_regs_retain(pul[9]), .o_watchdog_timer_run(run));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic rsi_kind_e xkind(logic [2:0] s, rsi_mode_t m);
    if (s[0]) return KIND_POR;
    if (s[1]) return KIND_LOW_VOLT;
    return m[1] ? KIND_WD_STANDBY : KIND_WD_RUN;
  endfunction : xkind
  function automatic logic [1:0] xflag(rsi_kind_e k, logic [1:0] f);
    case (k)
      KIND_POR: return 2'h0;
      KIND_LOW_VOLT: return f;
      KIND_WD_RUN: return {1'b1, f[0]};
      default: return 2'h3;
    endcase
  endfunction : xflag
  task automatic cmd(input logic a, input logic b);
    slp = a;
    wclr = b;
    @(negedge i_clock);
    slp = 1'b0;
    wclr = 1'b0;
    if (a | b) chk(16'({tmo, pdn}), 16'({1'b0, a}));
  endtask : cmd
  // a command offered while the clock enable is low must change nothing
  task automatic frz;
    logic [1:0] f;
    f = {tmo, pdn};
    ce = 1'b0;
    slp = !pdn;
    wclr = pdn;
    @(negedge i_clock);
    ce = 1'b1;
    slp = 1'b0;
    wclr = 1'b0;
    chk(16'({tmo, pdn}), 16'(f));
  endtask : frz
  // cpu reset must follow a source edge after three clock edges
  task automatic waitc(input logic v);
    int n;
    n = 0;
    while (crst !== v && n < 8) begin
      @(negedge i_clock);
      n++;
    end
    chk(16'({crst, 5'(n)}), 16'({v, 5'h03}));
  endtask : waitc
  task automatic apply(input logic [2:0] s, input logic up);
    logic [1:0] f;
    rsi_kind_e k;
    f = {tmo, pdn};
    k = up ? KIND_POR : xkind(s, mode);
    src = s;
    waitc(1'b1);
    if (up) begin
      src = 3'h1;
      repeat (3) @(negedge i_clock);
      chk(16'({kind, run}), 16'({KIND_POR, 1'b0}));
    end
    src = 3'h0;
    waitc(1'b0);
    chk(16'({kind, tmo, pdn, run}),
        16'({k, xflag(k, f), 1'b1}));
    chk(16'(pul),
        k == KIND_WD_STANDBY ? 16'h0206 : 16'h01FF);
    @(negedge i_clock);
    chk(16'(pul), 16'h0000);
  endtask : apply
  task automatic results;
    if (error_cnt == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results
  initial begin
    void'($urandom(32'hA7EB));
    repeat (20) @(negedge i_clock);
    i_rst_n = 1'b1;
    @(negedge i_clock);
    chk(16'({crst, kind, tmo, pdn, run}),
        16'({1'b0, KIND_POR, 3'h1}));
    chk(16'(pul), 16'h01FF);
    for (int i = 0; i < 48; i++) begin
      cmd(1'($urandom), 1'($urandom));
      if (i == 4) frz();
      if (i < 8) mode = rsi_mode_t'(tbl[i][4:3]);
      else mode = rsi_mode_t'($urandom_range(3, 0));
      apply(i < 8 ? tbl[i][2:0] : 3'($urandom_range(7, 1)), 1'b0);
    end
    mode = MODE_SLEEP;
    apply(3'h2, 1'b1);
    results();
  end
  initial begin
    repeat (20000) @(posedge i_clock);
    error_cnt++;
    results();
  end
endmodule : tb_top
bind rsi_reset_init rsi_properties i_rsi_properties (.i_clock, .i_rst_n,
  .i_power_on_reset, .o_cpu_reset, .o_reset_kind, .o_timeout_flag,
  .o_powerdown_flag, .o_pc_clear, .o_program_counter_low_clear,
  .o_stack_ptr_top, .o_int_disable_all, .o_watchdog_timer_run,
  .o_regs_reload, .o_regs_retain);
`default_nettype wire
